// ---- core/ugc_pkg.sv ----
// constants and carrier types for the general command handler
// How it works
// - ack-setup command re-enables control buffer commands
// - setup arrival blocks control buffer commands
// - codes A0..AF read one endpoint status byte
// - each transaction replaces endpoint status
// - bit 7 flags event before previous read
// - bit 6 holds last received data toggle
// - fault code bits 4..1, success bit 0
// - codes 0..3: none, pid check, unknown, unexpected
// - codes 4..9: crc, timeout, babble, eop, nak
// - codes A..C: stall, overflow, empty iso packet
// - codes D..F: stuffing, sync, wrong toggle
// - suspend blocks writes until unlocked after resume
// - unlock needs key AA37, low byte first
// - 16-bit scratch, B2 writes, B3 reads
// - B4 returns last good frame number
// - frame number low byte first, one or two
// - frame number is 11 bits, upper zero
// - frame number undefined after bus reset
// - select high for command, low for data
package ugc_pkg;
    localparam logic [7:0] CMD_ACK_SETUP = 8'hF4;
    localparam logic [3:0] CMD_ERR_NIBBLE = 4'hA;
    localparam logic [7:0] CMD_UNLOCK = 8'hB0;
    localparam logic [7:0] CMD_SCR_WR = 8'hB2;
    localparam logic [7:0] CMD_SCR_RD = 8'hB3;
    localparam logic [7:0] CMD_FRAME_RD = 8'hB4;
    localparam logic [15:0] UNLOCK_KEY = 16'hAA37;
    localparam logic [15:0] SCRATCH_RST = 16'h0000;
    localparam int FRAME_W = 11;
    localparam int ST_OVERRUN = 7;
    localparam int ST_TOGGLE = 6;
    localparam int ST_FAULT_LO = 1;
    localparam int ST_OK = 0;

    typedef enum logic [3:0] {
        FLT_NONE = 4'h0, FLT_PID_CHECK = 4'h1, FLT_PID_UNKNOWN = 4'h2, FLT_UNEXPECTED = 4'h3,
        FLT_TOKEN_CRC = 4'h4, FLT_DATA_CRC = 4'h5, FLT_TIMEOUT = 4'h6, FLT_BABBLE = 4'h7,
        FLT_EARLY_EOP = 4'h8, FLT_NAK = 4'h9, FLT_STALL = 4'hA, FLT_OVERFLOW = 4'hB,
        FLT_EMPTY_ISO = 4'hC, FLT_BITSTUFF = 4'hD, FLT_SYNC = 4'hE, FLT_TOGGLE = 4'hF
    } ugc_fault_t;

    typedef enum logic [2:0] {
        PH_IDLE = 3'h0, PH_WR_LO = 3'h1, PH_WR_HI = 3'h3, PH_RD_LO = 3'h2, PH_RD_HI = 3'h6
    } ugc_phase_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic cmdDataSelect;
        logic wide;
        logic [15:0] data;
    } ugc_bus_t;

    typedef struct packed {
        logic done;
        logic [3:0] ep;
        logic ok;
        logic rxData;
        logic toggle;
        ugc_fault_t fault;
    } ugc_txn_t;

    typedef struct packed {
        logic valid;
        logic [FRAME_W-1:0] frame;
    } ugc_sof_t;
endpackage : ugc_pkg

// ---- core/ugc_cmd.sv ----
// general command handler: setup ack, error codes, unlock, scratch, frame number
`timescale 1ns/1ps
module ugc_cmd import ugc_pkg::*; #(
    parameter int NUM_EP = 16
) (
    input wire logic ref_clk, // system clock, 40 MHz
    input wire logic arst_n, // async reset, active low
    input wire ugc_bus_t bus, // processor command/data strobe and word
    input wire ugc_txn_t txn, // transaction result from the serial engine
    input wire ugc_sof_t sof, // good start-of-frame with its number
    input wire logic setupRcvd, // setup packet arrived, pulse
    input wire logic suspend, // bus suspend level
    output logic [15:0] readData, // data for the next read strobe
    output logic ctrlBufCmdEnable, // control validate/clear allowed
    output logic writeLocked // register and fifo writes blocked
);
    initial begin
        if (NUM_EP < 2 || NUM_EP > 16) begin
            $error("NUM_EP must lie in 2..16");
        end
    end

    typedef struct packed {
        ugc_phase_t phase;
        logic wrScratch;
        logic [7:0] wrLow;
        logic [15:0] rdWord;
        logic rdErr;
        logic [3:0] rdEp;
        logic [15:0] readData;
        logic [15:0] scratch;
        logic [FRAME_W-1:0] frame;
        logic setupBlocked;
        logic writeLocked;
        logic [NUM_EP-1:0] pending;
        logic [NUM_EP-1:0][7:0] status;
    } ugc_state_t;

    localparam ugc_state_t ST_RST = '{phase: PH_IDLE, scratch: SCRATCH_RST, default: '0};

    ugc_state_t st;
    ugc_state_t next_st;

    logic cmdWr;
    logic datWr;
    logic datRd;
    logic [7:0] code;
    logic ackCmd;
    logic errCmd;
    logic scrCmd;
    logic frameCmd;
    logic keyHit;
    logic errRdDone;
    logic txnValid;

    // upper command byte on a wide bus is never looked at
    assign cmdWr = bus.wr & bus.cmdDataSelect;
    assign datWr = bus.wr & ~bus.cmdDataSelect;
    assign datRd = bus.rd & ~bus.cmdDataSelect;
    assign code = bus.data[7:0];
    assign ackCmd = cmdWr && code == CMD_ACK_SETUP;
    assign errCmd = cmdWr && code[7:4] == CMD_ERR_NIBBLE && 32'(code[3:0]) < NUM_EP;
    assign scrCmd = cmdWr && code == CMD_SCR_RD;
    assign frameCmd = cmdWr && code == CMD_FRAME_RD;
    assign txnValid = txn.done && 32'(txn.ep) < NUM_EP;
    assign errRdDone = datRd && st.phase == PH_RD_LO && st.rdErr;

    always_comb begin
        logic [15:0] word;
        logic doWrite;
        logic [7:0] entry;
        next_st = st;
        word = 16'h0000;
        doWrite = 1'b0;
        entry = 8'h00;
        keyHit = 1'b0;

        if (cmdWr) begin
            // a new command abandons any half-done transfer
            next_st.phase = PH_IDLE;
            next_st.rdErr = 1'b0;
            case (code)
                CMD_ACK_SETUP: begin
                    next_st.setupBlocked = 1'b0;
                end
                CMD_UNLOCK: begin
                    next_st.phase = PH_WR_LO;
                    next_st.wrScratch = 1'b0;
                end
                CMD_SCR_WR: begin
                    // refused while locked: the data phase falls on idle and is dropped
                    if (!st.writeLocked) begin
                        next_st.phase = PH_WR_LO;
                        next_st.wrScratch = 1'b1;
                    end
                end
                CMD_SCR_RD: begin
                    next_st.rdWord = st.scratch;
                    next_st.readData = bus.wide ? st.scratch : {8'h00, st.scratch[7:0]};
                    next_st.phase = PH_RD_LO;
                end
                CMD_FRAME_RD: begin
                    next_st.rdWord = {{(16 - FRAME_W){1'b0}}, st.frame};
                    next_st.readData = bus.wide ? {{(16 - FRAME_W){1'b0}}, st.frame} : {8'h00, st.frame[7:0]};
                    next_st.phase = PH_RD_LO;
                end
                default: begin
                    if (errCmd) begin
                        next_st.rdErr = 1'b1;
                        next_st.rdEp = code[3:0];
                        next_st.readData = {8'h00, st.status[code[3:0]]};
                        next_st.phase = PH_RD_LO;
                    end
                end
            endcase
        end else if (datWr) begin
            case (st.phase)
                PH_WR_LO: begin
                    if (bus.wide) begin
                        word = bus.data;
                        doWrite = 1'b1;
                    end else begin
                        next_st.wrLow = bus.data[7:0];
                        next_st.phase = PH_WR_HI;
                    end
                end
                PH_WR_HI: begin
                    word = {bus.data[7:0], st.wrLow};
                    doWrite = 1'b1;
                end
                default: begin
                end
            endcase
        end else if (datRd) begin
            case (st.phase)
                PH_RD_LO: begin
                    if (st.rdErr) begin
                        next_st.pending[st.rdEp] = 1'b0;
                        next_st.rdErr = 1'b0;
                        next_st.phase = PH_IDLE;
                    end else if (bus.wide) begin
                        next_st.phase = PH_IDLE;
                    end else begin
                        next_st.readData = {8'h00, st.rdWord[15:8]};
                        next_st.phase = PH_RD_HI;
                    end
                end
                PH_RD_HI: begin
                    next_st.phase = PH_IDLE;
                end
                default: begin
                end
            endcase
        end

        if (doWrite) begin
            next_st.phase = PH_IDLE;
            if (st.wrScratch) begin
                if (!st.writeLocked) begin
                    next_st.scratch = word;
                end
            end else if (word == UNLOCK_KEY) begin
                keyHit = 1'b1;
                next_st.writeLocked = 1'b0;
            end
        end

        // hardware events come last so that they win over any clear
        if (suspend) begin
            next_st.writeLocked = 1'b1;
        end
        if (setupRcvd) begin
            next_st.setupBlocked = 1'b1;
        end
        // after a bus reset the number stays stale until the next good frame
        if (sof.valid) begin
            next_st.frame = sof.frame;
        end
        if (txnValid) begin
            // pending already dropped if this cycle's read took the old value
            entry[ST_OVERRUN] = next_st.pending[txn.ep];
            entry[ST_TOGGLE] = (txn.ok && txn.rxData) ? txn.toggle : st.status[txn.ep][ST_TOGGLE];
            entry[ST_FAULT_LO +: 4] = txn.fault;
            entry[ST_OK] = txn.ok;
            next_st.status[txn.ep] = entry;
            next_st.pending[txn.ep] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign readData = st.readData;
    assign ctrlBufCmdEnable = ~st.setupBlocked;
    assign writeLocked = st.writeLocked;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    setup_block_a: assert property (
        setupRcvd |=> !ctrlBufCmdEnable
    ) else $error("setup did not block control buffer commands");

    setup_ack_a: assert property (
        ackCmd && !setupRcvd |=> ctrlBufCmdEnable
    ) else $error("acknowledge setup did not re-enable commands");

    ack_only_a: assert property (
        $rose(ctrlBufCmdEnable) |-> $past(ackCmd)
    ) else $error("control commands re-enabled without acknowledge");

    suspend_lock_a: assert property (
        suspend |=> writeLocked
    ) else $error("suspend did not lock writes");

    unlock_key_a: assert property (
        $fell(writeLocked) |-> $past(keyHit) && $past(st.phase) inside {PH_WR_LO, PH_WR_HI}
    ) else $error("lock released without the key");

    lock_keep_a: assert property (
        writeLocked && !keyHit |=> writeLocked
    ) else $error("lock released by a wrong key or write");

    scratch_prot_a: assert property (
        writeLocked |=> $stable(st.scratch)
    ) else $error("scratch changed while writes are locked");

    scratch_rd_a: assert property (
        scrCmd && !bus.wide |=> readData == {8'h00, st.scratch[7:0]}
    ) else $error("scratch readback low byte wrong");

    frame_cap_a: assert property (
        sof.valid |=> st.frame == $past(sof.frame)
    ) else $error("frame number not captured");

    frame_rd_a: assert property (
        frameCmd && bus.wide |=> readData == {5'h00, $past(st.frame)}
    ) else $error("wide frame number readback wrong");

    frame_low_a: assert property (
        st.phase == PH_RD_LO && !st.rdErr && datRd && !bus.wr && !bus.wide |=> readData == {8'h00, $past(st.rdWord[15:8])}
    ) else $error("high byte not offered after the low byte");

    txn_store_a: assert property (
        txnValid |=> st.status[$past(txn.ep)][4:1] == $past(txn.fault) && st.status[$past(txn.ep)][0] == $past(txn.ok)
    ) else $error("transaction status not stored");

    overrun_a: assert property (
        txnValid && st.pending[txn.ep] && !(errRdDone && st.rdEp == txn.ep) |=> st.status[$past(txn.ep)][7]
    ) else $error("overrun flag missing");

    toggle_a: assert property (
        txnValid && txn.ok && txn.rxData |=> st.status[$past(txn.ep)][6] == $past(txn.toggle)
    ) else $error("data toggle not recorded");

    err_rd_a: assert property (
        errCmd |=> readData[15:8] == 8'h00 && !readData[5] && st.phase == PH_RD_LO
    ) else $error("error code readback malformed");

    // status byte contents and the status_overrun mark
    reserved_bit_a: assert property (
        txnValid |=> !st.status[$past(txn.ep)][5]
    ) else $error("reserved status bit set");

    toggle_keep_a: assert property (
        txnValid && !(txn.ok && txn.rxData) |=> st.status[$past(txn.ep)][6] == $past(st.status[txn.ep][6])
    ) else $error("data toggle changed without a good data packet");

    overrun_clear_a: assert property (
        txnValid && !st.pending[txn.ep] |=> !st.status[$past(txn.ep)][7]
    ) else $error("overrun flag set although status was read");

    pending_set_a: assert property (
        txnValid |=> st.pending[$past(txn.ep)]
    ) else $error("status_overrun mark not set by a transaction");

    err_rd_clear_a: assert property (
        errRdDone && !bus.wr && !(txnValid && txn.ep == st.rdEp) |=> !st.pending[$past(st.rdEp)]
    ) else $error("reading the status did not clear the status_overrun mark");

    err_data_a: assert property (
        errCmd |=> readData[7:0] == $past(st.status[code[3:0]])
    ) else $error("error code readback not the stored status");

    status_hold_a: assert property (
        !txnValid |=> $stable(st.status)
    ) else $error("status changed without a transaction");

    // scratch register
    scratch_wr_a: assert property (
        datWr && st.phase == PH_WR_HI && st.wrScratch && !st.writeLocked |=> st.scratch == $past({bus.data[7:0], st.wrLow})
    ) else $error("scratch write not stored low byte first");

    scratch_wide_a: assert property (
        scrCmd && bus.wide |=> readData == $past(st.scratch)
    ) else $error("wide scratch readback wrong");

    wr_closed_a: assert property (
        datWr && st.phase == PH_IDLE |=> $stable(st.scratch)
    ) else $error("data write without open phase changed scratch");

    phase_closed_a: assert property (
        (datRd || datWr) && st.phase == PH_IDLE |=> st.phase == PH_IDLE
    ) else $error("data strobe opened a transfer without a command");

    // frame number
    frame_upper_a: assert property (
        frameCmd |=> readData[15:11] == 5'h00
    ) else $error("reserved frame number bits not zero");

    frame_hold_a: assert property (
        !sof.valid |=> $stable(st.frame)
    ) else $error("frame number changed without a good frame");

    // write lock and setup gating
    key_bad_a: assert property (
        datWr && st.phase == PH_WR_HI && !st.wrScratch && {bus.data[7:0], st.wrLow} != UNLOCK_KEY && writeLocked
        |=> writeLocked
    ) else $error("wrong key released the lock");

    unlock_ok_a: assert property (
        keyHit && !suspend |=> !writeLocked
    ) else $error("correct key did not release the lock");

    lock_rise_a: assert property (
        $rose(writeLocked) |-> $past(suspend)
    ) else $error("lock set without suspend");

    unlock_stays_a: assert property (
        !writeLocked && !suspend |=> !writeLocked
    ) else $error("lock set while awake");

    setup_hold_a: assert property (
        !ctrlBufCmdEnable && !ackCmd |=> !ctrlBufCmdEnable
    ) else $error("control commands re-enabled without acknowledge");

    enable_hold_a: assert property (
        ctrlBufCmdEnable && !setupRcvd |=> ctrlBufCmdEnable
    ) else $error("control commands blocked without setup");

endmodule : ugc_cmd

// ---- dv/ugc_host_model.sv ----
// processor model driving the command/data port
`timescale 1ns/1ps
module ugc_host_model import ugc_pkg::*; (
    input wire logic ref_clk, // system clock
    input wire logic [15:0] readData, // word offered for the next read
    output ugc_bus_t bus // strobes, select and word
);
    logic wide16 = 1'b0;
    initial bus = '0;
    // released lines carry inverted data so a stale byte cannot pass
    task automatic xfer(input logic w, input logic sel, input logic [15:0] d, output logic [15:0] q);
        @(negedge ref_clk);
        q = readData;
        bus <= '{w, ~w, sel, wide16, d};
        @(negedge ref_clk);
        bus <= '{1'b0, 1'b0, ~sel, wide16, ~d};
    endtask : xfer
endmodule : ugc_host_model

// ---- dv/test_usb_device_general_commands.sv ----
// self-checking bench for the general command handler
`timescale 1ns/1ps
module test_usb_device_general_commands import ugc_pkg::*;;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    ugc_bus_t bus;
    ugc_txn_t txn = '0;
    ugc_sof_t sof = '0;
    logic setupRcvd = 1'b0;
    logic suspend = 1'b0;
    logic [15:0] readData;
    logic ctrlBufCmdEnable;
    logic writeLocked;
    logic [15:0] q;
    int nMismatch = 0;
    int numChecks = 0;
    int cycles = 0;

    always #12.5 ref_clk = ~ref_clk;

    ugc_cmd i_ugc_cmd (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus), .txn(txn), .sof(sof),
        .setupRcvd(setupRcvd), .suspend(suspend), .readData(readData),
        .ctrlBufCmdEnable(ctrlBufCmdEnable), .writeLocked(writeLocked));
    ugc_host_model i_ugc_host_model (.ref_clk(ref_clk), .readData(readData), .bus(bus));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wrapUp();
        if (nMismatch == 0 && numChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrapUp

    // upper byte set on purpose: the handler must ignore it for commands
    task automatic cmd(input logic [7:0] c);
        i_ugc_host_model.xfer(1'b1, 1'b1, {8'hC3, c}, q);
    endtask : cmd
    task automatic wr(input logic [15:0] d);
        i_ugc_host_model.xfer(1'b1, 1'b0, d, q);
    endtask : wr
    task automatic rd(input logic [15:0] e);
        i_ugc_host_model.xfer(1'b0, 1'b0, 16'h0000, q);
        check(q, e);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : idle
    task automatic lk(input logic e);
        idle(1);
        check(16'(writeLocked), 16'(e));
    endtask : lk
    task automatic post(input logic [3:0] ep, input logic [3:0] f, input logic ok);
        @(negedge ref_clk);
        txn = '{1'b1, ep, ok, 1'b1, 1'b1, ugc_fault_t'(f)};
        @(negedge ref_clk);
        txn.done = 1'b0;
    endtask : post

    task automatic tReset();
        check(readData, 16'h0000);
        check(16'(ctrlBufCmdEnable), 16'h0001);
        lk(1'b0);
        cmd(CMD_SCR_RD);
        rd(16'h0000);
        rd(16'h0000);
    endtask : tReset

    task automatic tScratch();
        cmd(CMD_SCR_WR);
        wr(16'h005A);
        wr(16'h00C3);
        cmd(CMD_SCR_RD);
        rd(16'h005A);
        rd(16'h00C3);
    endtask : tScratch

    task automatic tLock();
        @(negedge ref_clk);
        suspend = 1'b1;
        lk(1'b1);
        cmd(CMD_UNLOCK);
        wr(16'h0037);
        wr(16'h00AA);
        lk(1'b1);
        suspend = 1'b0;
        lk(1'b1);
        cmd(CMD_UNLOCK);
        wr(16'h00AA);
        wr(16'h0037);
        lk(1'b1);
        cmd(CMD_SCR_WR);
        wr(16'h0011);
        wr(16'h0022);
        cmd(CMD_UNLOCK);
        wr(16'h0037);
        wr(16'h00AA);
        lk(1'b0);
        cmd(CMD_SCR_RD);
        rd(16'h005A);
        rd(16'h00C3);
    endtask : tLock

    task automatic tSetup();
        @(negedge ref_clk);
        setupRcvd = 1'b1;
        @(negedge ref_clk);
        setupRcvd = 1'b0;
        idle(1);
        check(16'(ctrlBufCmdEnable), 16'h0000);
        cmd(CMD_ACK_SETUP);
        idle(1);
        check(16'(ctrlBufCmdEnable), 16'h0001);
    endtask : tSetup

    // one endpoint per fault code, so every code is read back once
    task automatic tStatus();
        for (int k = 0; k < 16; k++) begin
            post(4'(k), 4'(k), k[0]);
            cmd({CMD_ERR_NIBBLE, 4'(k)});
            rd({8'h00, 1'b0, k[0], 1'b0, 4'(k), k[0]});
        end
        post(4'h2, 4'h6, 1'b0);
        post(4'h2, 4'h5, 1'b0);
        cmd(8'hA2);
        rd(16'h008A);
        post(4'h2, 4'h9, 1'b1);
        cmd(8'hA2);
        rd(16'h0053);
    endtask : tStatus

    task automatic tFrame();
        @(negedge ref_clk);
        sof = '{1'b1, 11'h5A3};
        @(negedge ref_clk);
        sof.valid = 1'b0;
        cmd(CMD_FRAME_RD);
        rd(16'h00A3);
        rd(16'h0005);
        cmd(CMD_FRAME_RD);
        rd(16'h00A3);
        i_ugc_host_model.wide16 = 1'b1;
        cmd(CMD_FRAME_RD);
        rd(16'h05A3);
        i_ugc_host_model.wide16 = 1'b0;
    endtask : tFrame

    // hang guard, well above the two hundred or so cycles the run needs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            nMismatch++;
            wrapUp();
        end
    end

    initial begin
        idle(6);
        arst_n = 1'b1;
        tReset();
        tScratch();
        tLock();
        tSetup();
        tStatus();
        tFrame();
        wrapUp();
    end
endmodule : test_usb_device_general_commands
